//--- rtl/sep_pkg.sv
// constants, opcodes, status layout and states of the command and protection block
// Behaviour
// R1 - memory and status writes run only when the clock count is a multiple of eight
// R2 - data or status changing commands need the write latch set beforehand
// R3 - a command runs only when select rises right after its last bit
// R4 - protect size 00 none, 01 0300h-03FFh, 10 0200h-03FFh, 11 whole array
// R5 - memory writes into the protected region are refused, bytes stay unchanged
// R6 - protect size bits are non-volatile, set by status write outside hard protect
// R7 - commands are whole bytes, msb first, the first byte is the opcode
// R8 - an unknown opcode makes the device ignore input and drive nothing until deselect
// R9 - opcodes 06 set latch, 04 clear latch, 05/01 status read/write, 03/02 array
// R10 - opcode 83 reads id page or lock state, 82 writes id page or locks it
// R11 - array address is two bytes, only the ten low bits count
// R12 - id page uses A4..A0 with upper bits zero, lock commands use only b10 set
// R13 - set latch opcode is the only way to set the latch, at deselect
// R14 - clear latch opcode clears the latch at deselect
// R15 - latch clears at power-up, clear command and end of a status or memory write
// R16 - status read is accepted at any time, also during a write cycle
// R17 - status read keeps shifting the current status byte while selected
// R18 - master should poll the cycle flag before the next command
// R19 - cycle flag is one during a memory or status write cycle, else zero
// R20 - with the latch clear no memory or status write is accepted
// R21 - lock bit set and protect pin low freeze the non-volatile bits
// R22 - status byte: lock, three zeros, size hi, size lo, latch, cycle flag
// R23 - power-on reset clears latch and cycle flag, keeps non-volatile bits
// R24 - input sampled on rising clock edges, output driven after falling edges
// R25 - array reads are ignored while a write cycle runs
// R26 - end of the internal write cycle clears cycle flag and latch together
package sep_pkg;
    // opcodes
    localparam logic [7:0]  OP_SET_LATCH = 8'h06;
    localparam logic [7:0]  OP_CLR_LATCH = 8'h04;
    localparam logic [7:0]  OP_STAT_RD   = 8'h05;
    localparam logic [7:0]  OP_STAT_WR   = 8'h01;
    localparam logic [7:0]  OP_ARR_RD    = 8'h03;
    localparam logic [7:0]  OP_ARR_WR    = 8'h02;
    localparam logic [7:0]  OP_ID_RD     = 8'h83;
    localparam logic [7:0]  OP_ID_WR     = 8'h82;
    // address layout
    localparam int          ADDR_BITS    = 10;
    localparam logic [15:0] ID_LOCK_ADDR = 16'h0400;
    localparam logic [15:0] ID_ADDR_MASK = 16'h001f;
    localparam logic [9:0]  PROT_QUARTER = 10'h300;
    localparam logic [9:0]  PROT_HALF    = 10'h200;
    // status byte bit positions
    localparam int          ST_LOCK      = 7;
    localparam int          ST_BP_HI     = 3;
    localparam int          ST_BP_LO     = 2;
    localparam int          ST_LATCH     = 1;
    localparam int          ST_BUSY      = 0;
    // byte counts of complete commands, byte positions in a frame and the last bit index
    localparam logic [2:0]  NB_OPCODE    = 3'h1;
    localparam logic [2:0]  NB_STAT_WR   = 3'h2;
    localparam logic [2:0]  NB_ADDR_HI   = 3'h1;
    localparam logic [2:0]  NB_ADDR_LO   = 3'h2;
    localparam logic [2:0]  NB_DATA      = 3'h3;
    localparam logic [2:0]  NB_SAT       = 3'h4;
    localparam logic [2:0]  BIT_LAST     = 3'h7;
    // write cycle time
    localparam int          TW_NS        = 5000000;
    localparam int          CLK_NS       = 10;
    localparam int          TW_CYCLES    = TW_NS / CLK_NS;
    // kinds of started write cycle
    localparam logic [1:0]  WK_ARRAY     = 2'h0;
    localparam logic [1:0]  WK_STATUS    = 2'h1;
    localparam logic [1:0]  WK_ID_PAGE   = 2'h2;
    localparam logic [1:0]  WK_ID_LOCK   = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CYCLE = 2'b01,
        ST_DONE  = 2'b11
    } sep_state_t;
endpackage : sep_pkg

//--- rtl/sep_cmd_protect.sv
// opcode decoder, write latch and block protection of the serial memory
`timescale 1ns/100ps
`default_nettype none
module sep_cmd_protect #(
    parameter int WRITE_CYCLES = sep_pkg::TW_CYCLES, // internal write cycle length
    parameter bit HAS_ID_PAGE  = 1'b1                 // id page opcodes supported
) (
    input  wire logic        clk,           // system clock
    input  wire logic        rst_n,         // power-on reset, active low
    input  wire logic        sck,           // serial bus clock
    input  wire logic        cs_n,          // chip select, active low
    input  wire logic        mosi,          // serial data in
    output var  logic        sdo_o,         // serial data out
    output var  logic        sdo_oe,        // serial data out enable
    input  wire logic        protect_pin_n, // protect pin, active low
    input  wire logic [2:0]  nv_init,       // stored lock and size bits at power-up
    output var  logic [2:0]  nv_bits,       // current lock and size bits
    input  wire logic [7:0]  rd_data,       // array byte at rd_addr, sck domain
    output var  logic [9:0]  rd_addr,       // array read address, sck domain
    output var  logic        wr_start,      // one-cycle pulse, array or id write cycle begins
    output var  logic [1:0]  wr_kind,       // kind of write cycle started
    output var  logic [15:0] wr_addr,       // start address of the write
    output var  logic [7:0]  status_o       // status byte
);
    localparam int CW = $clog2(WRITE_CYCLES + 1);

    if (WRITE_CYCLES < 2) begin : g_chk
        $error("WRITE_CYCLES must be at least 2");
    end

    // ------------------------------------------------------------
    // link side, bus clock
    // ------------------------------------------------------------
    logic       in_frame_q;
    logic [2:0] bitcnt_q;
    logic [2:0] bytecnt_q;
    logic [7:0] sh_q;
    logic [7:0] op_q;
    logic [15:0] addr_q;
    logic [7:0] data_q;
    logic       bad_q;
    logic [7:0] stat_s1_q;
    logic [7:0] stat_s2_q;
    logic [7:0] out_q;
    logic       oe_q;
    logic [2:0] fbit;
    logic [2:0] fbyte;
    logic [7:0] sh_d;
    logic       op_ok;
    logic       is_rd;

    // frame marker, cleared by deselect
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            in_frame_q <= 1'b0;
        end else begin
            in_frame_q <= 1'b1;
        end
    end

    assign fbit  = in_frame_q ? bitcnt_q : 3'h0;
    assign fbyte = in_frame_q ? bytecnt_q : 3'h0;
    assign sh_d  = {sh_q[6:0], mosi};

    // supported opcode set
    always_comb begin
        unique case (sh_d)
            sep_pkg::OP_SET_LATCH, sep_pkg::OP_CLR_LATCH, sep_pkg::OP_STAT_RD,
            sep_pkg::OP_STAT_WR, sep_pkg::OP_ARR_RD, sep_pkg::OP_ARR_WR: op_ok = 1'b1;
            sep_pkg::OP_ID_RD, sep_pkg::OP_ID_WR: op_ok = HAS_ID_PAGE; // see R10
            default: op_ok = 1'b0;
        endcase
    end

    // shifter and byte parser; state persists after deselect for the clk side
    always_ff @(posedge sck) begin // see R24
        if (!(in_frame_q && bad_q)) begin // see R8
            sh_q     <= sh_d; // see R7
            bitcnt_q <= fbit + 3'h1;
            bad_q    <= 1'b0;
            if (!in_frame_q) begin
                bytecnt_q <= 3'h0;
            end
            if (fbit == sep_pkg::BIT_LAST) begin
                if (fbyte != sep_pkg::NB_SAT) begin
                    bytecnt_q <= fbyte + 3'h1;
                end
                if (fbyte == 3'h0) begin
                    op_q  <= sh_d; // see R7
                    bad_q <= !op_ok; // see R8
                end
                if (fbyte == sep_pkg::NB_ADDR_HI) begin
                    addr_q[15:8] <= sh_d;
                    data_q       <= sh_d;
                end
                if (fbyte == sep_pkg::NB_ADDR_LO) begin
                    addr_q[7:0] <= sh_d;
                    rd_addr     <= {addr_q[9:8], sh_d}; // see R11
                end
                if (fbyte >= sep_pkg::NB_DATA) begin
                    rd_addr <= rd_addr + 10'h001;
                end
            end
        end
    end

    // status byte into the bus clock domain
    always_ff @(posedge sck) begin
        stat_s1_q <= status_o;
        stat_s2_q <= stat_s1_q;
    end

    assign is_rd = (op_q == sep_pkg::OP_ARR_RD) || (op_q == sep_pkg::OP_ID_RD);

    // output shifter on falling edges
    always_ff @(negedge sck or posedge cs_n) begin // see R24
        if (cs_n) begin
            out_q <= 8'h00;
            oe_q  <= 1'b0;
        end else if (in_frame_q && !bad_q && bitcnt_q == 3'h0
                     && op_q == sep_pkg::OP_STAT_RD && bytecnt_q != 3'h0) begin
            out_q <= stat_s2_q; // see R16, R17
            oe_q  <= 1'b1;
        end else if (in_frame_q && !bad_q && bitcnt_q == 3'h0 && is_rd
                     && bytecnt_q >= sep_pkg::NB_DATA && !stat_s2_q[sep_pkg::ST_BUSY]) begin
            out_q <= rd_data; // see R25
            oe_q  <= 1'b1;
        end else begin
            out_q <= {out_q[6:0], 1'b0};
        end
    end

    assign sdo_o  = out_q[7];
    assign sdo_oe = oe_q;

    // ------------------------------------------------------------
    // system clock side
    // ------------------------------------------------------------
    logic       cs_s1_q, cs_s2_q, cs_s3_q;
    logic       wp_s1_q, wp_s2_q;
    logic       latch_q;
    logic [2:0] nv_q;
    logic [2:0] pend_q;
    logic [1:0] kind_q;
    logic [CW-1:0] cnt_q;
    sep_pkg::sep_state_t state_q;
    logic       end_evt;
    logic       whole;
    logic       hard_protect_mode;
    logic       busy;
    logic       prot;
    logic       go;
    logic [1:0] go_kind;
    logic       set_l, clr_l;

    // select and protect pin synchronisers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
        end else begin
            cs_s1_q <= cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            wp_s1_q <= protect_pin_n;
            wp_s2_q <= wp_s1_q;
        end
    end

    assign end_evt = cs_s2_q && !cs_s3_q;
    assign whole   = (bitcnt_q == 3'h0) && !bad_q; // see R1, R3
    assign hard_protect_mode     = nv_q[2] && !wp_s2_q; // see R21
    assign busy    = (state_q != sep_pkg::ST_IDLE);

    // protected region decode
    always_comb begin
        unique case (nv_q[1:0]) // see R4
            2'b00: prot = 1'b0;
            2'b01: prot = addr_q[9:0] >= sep_pkg::PROT_QUARTER;
            2'b10: prot = addr_q[9:0] >= sep_pkg::PROT_HALF;
            2'b11: prot = 1'b1;
        endcase
    end

    // command execution at deselect
    always_comb begin
        go      = 1'b0;
        go_kind = sep_pkg::WK_ARRAY;
        set_l   = 1'b0;
        clr_l   = 1'b0;
        if (end_evt && whole && !busy) begin
            unique case (op_q)
                sep_pkg::OP_SET_LATCH: set_l = (bytecnt_q == sep_pkg::NB_OPCODE); // see R13
                sep_pkg::OP_CLR_LATCH: clr_l = (bytecnt_q == sep_pkg::NB_OPCODE); // see R14
                sep_pkg::OP_STAT_WR: begin
                    go      = (bytecnt_q == sep_pkg::NB_STAT_WR) && latch_q && !hard_protect_mode; // see R6, R20
                    go_kind = sep_pkg::WK_STATUS;
                end
                sep_pkg::OP_ARR_WR: begin
                    go = (bytecnt_q == sep_pkg::NB_SAT) && latch_q && !prot; // see R2, R5
                end
                sep_pkg::OP_ID_WR: begin
                    if (addr_q == sep_pkg::ID_LOCK_ADDR) begin // see R12
                        go_kind = sep_pkg::WK_ID_LOCK;
                        go      = (bytecnt_q == sep_pkg::NB_SAT) && latch_q;
                    end else begin
                        go_kind = sep_pkg::WK_ID_PAGE;
                        go      = (bytecnt_q == sep_pkg::NB_SAT) && latch_q
                                  && ((addr_q & ~sep_pkg::ID_ADDR_MASK) == 16'h0000);
                    end
                end
                default: ;
            endcase
        end
    end

    // write cycle sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= sep_pkg::ST_IDLE; // see R23
            cnt_q   <= '0;
        end else begin
            unique case (state_q)
                sep_pkg::ST_IDLE: if (go) begin
                    state_q <= sep_pkg::ST_CYCLE;
                    cnt_q   <= CW'(WRITE_CYCLES - 2);
                end
                sep_pkg::ST_CYCLE: if (cnt_q == '0) begin
                    state_q <= sep_pkg::ST_DONE;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
                sep_pkg::ST_DONE: state_q <= sep_pkg::ST_IDLE;
            endcase
        end
    end

    // write latch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_q <= 1'b0; // see R15, R23
        end else if (set_l) begin
            latch_q <= 1'b1; // see R13
        end else if (clr_l || state_q == sep_pkg::ST_DONE) begin
            latch_q <= 1'b0; // see R14, R26
        end
    end

    // non-volatile bits, committed at the end of a status write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nv_q   <= nv_init; // see R23
            pend_q <= 3'h0;
            kind_q <= sep_pkg::WK_ARRAY;
        end else begin
            if (go) begin
                pend_q <= {data_q[sep_pkg::ST_LOCK], data_q[sep_pkg::ST_BP_HI],
                           data_q[sep_pkg::ST_BP_LO]};
                kind_q <= go_kind;
            end
            if (state_q == sep_pkg::ST_DONE && kind_q == sep_pkg::WK_STATUS) begin
                nv_q <= pend_q; // see R6
            end
        end
    end

    // write start toward the array
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_start <= 1'b0;
            wr_kind  <= sep_pkg::WK_ARRAY;
            wr_addr  <= 16'h0000;
        end else begin
            wr_start <= go && (go_kind != sep_pkg::WK_STATUS);
            if (go) begin
                wr_kind <= go_kind;
                wr_addr <= (go_kind == sep_pkg::WK_ARRAY) ? {6'h00, addr_q[9:0]} : addr_q;
            end
        end
    end

    // status byte
    assign status_o = {nv_q[2], 3'b000, nv_q[1:0], latch_q, busy}; // see R19, R22
    assign nv_bits  = nv_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // length of the running write cycle in clock cycles
    logic [CW-1:0] busy_len_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_len_q <= '0;
        end else if (busy) begin
            busy_len_q <= busy_len_q + 1'b1;
        end else begin
            busy_len_q <= '0;
        end
    end

    chk_latch_set: assert property ( // see R13
        end_evt && whole && !busy && op_q == sep_pkg::OP_SET_LATCH
        && bytecnt_q == sep_pkg::NB_OPCODE |=> latch_q)
        else $error("latch not set after set command");
    chk_latch_clr: assert property ( // see R14
        end_evt && whole && !busy && op_q == sep_pkg::OP_CLR_LATCH
        && bytecnt_q == sep_pkg::NB_OPCODE |=> !latch_q)
        else $error("latch not cleared after clear command");
    chk_cycle_needs_latch: assert property ( // see R20
        $rose(busy) |-> $past(latch_q))
        else $error("write cycle began without latch");
    chk_cycle_whole_bytes: assert property ( // see R1
        $rose(busy) |-> $past(bitcnt_q) == 3'h0 && $past(end_evt))
        else $error("write cycle began on partial byte");
    chk_end_clears: assert property ( // see R26
        $fell(busy) |-> !latch_q)
        else $error("latch still set after write cycle");
    chk_hpm_blocks: assert property ( // see R21
        $rose(busy) && kind_q == sep_pkg::WK_STATUS |-> !$past(hard_protect_mode))
        else $error("status write started in hard protect");
    chk_nv_only_at_end: assert property ( // see R6
        $past(state_q) != sep_pkg::ST_DONE |-> $stable(nv_q))
        else $error("protect bits changed outside cycle end");
    chk_no_prot_write: assert property ( // see R5
        go && go_kind == sep_pkg::WK_ARRAY |-> !prot ##1 wr_start)
        else $error("write into protected region");
    chk_busy_length: assert property ( // see R19
        $fell(busy) |-> busy_len_q == CW'(WRITE_CYCLES))
        else $error("write cycle length wrong");
    chk_quiet_on_bad: assert property ( // see R8
        @(negedge sck) disable iff (cs_n) $rose(oe_q) |-> !bad_q)
        else $error("output driven after unknown opcode");

    cov_set_latch: cover property (set_l);
    cov_status_wr: cover property (go && go_kind == sep_pkg::WK_STATUS);
    cov_array_wr:  cover property (wr_start && wr_kind == sep_pkg::WK_ARRAY);
    cov_refused:   cover property (end_evt && op_q == sep_pkg::OP_ARR_WR && prot);
endmodule : sep_cmd_protect
`default_nettype wire

//--- tb/sep_spi_master_model.sv
// behavioural serial bus master that drives the command block
`timescale 1ns/100ps
`default_nettype none
module sep_spi_master_model #(
    parameter int HALF_NS = 16 // half serial clock period
) (
    output var  logic sck,    // serial clock, still between frames
    output var  logic cs_n,   // chip select, active low
    output var  logic mosi,   // serial data to the device
    input  wire logic sdo_o,  // serial data from the device
    input  wire logic sdo_oe  // device drives sdo_o
);
    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    initial begin
        sck  = 1'b0; // mode 0 idle level
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // ------------------------------------------------------------
    // one frame: nbits of tx msb first, rx collects sampled output
    // ------------------------------------------------------------
    task automatic frame(input logic [31:0] tx, input int nbits,
                         output logic [31:0] rx, output logic oe_seen);
        rx      = 32'h0;
        oe_seen = 1'b0;
        #3;
        cs_n = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            mosi = tx[i]; // msb first, nbits may end in a partial byte
            #(HALF_NS);
            sck     = 1'b1; // device samples here
            rx      = {rx[30:0], sdo_o};
            oe_seen = oe_seen | (sdo_oe === 1'b1);
            #(HALF_NS);
            sck = 1'b0;
        end
        #(HALF_NS / 2);
        cs_n = 1'b1; // rise after the last rising edge, before the next
        mosi = ~mosi; // released line does not keep its value
        #(HALF_NS * 4);
    endtask : frame
endmodule : sep_spi_master_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the command and protection block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int WCYC = 100; // shortened write cycle
    logic        clk;
    logic        rst_n;
    logic        sck;
    logic        cs_n;
    logic        mosi;
    logic        sdo_o;
    logic        sdo_oe;
    logic        protect_pin_n;
    logic [2:0]  nv_init;
    logic [2:0]  nv_bits;
    logic [9:0]  rd_addr;
    logic        wr_start;
    logic [1:0]  wr_kind;
    logic [15:0] wr_addr;
    logic [7:0]  status_o;
    logic [31:0] rx;
    logic        oe_seen;
    logic        acc;
    int          errors = 0;
    int          n_checks = 0;
    int          n_starts = 0;
    int          cycles = 0;
    int          lim;
    int          s0;

    sep_cmd_protect #(.WRITE_CYCLES(WCYC), .HAS_ID_PAGE(1'b1)) i_sep_cmd_protect (
        .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .mosi(mosi),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .protect_pin_n(protect_pin_n),
        .nv_init(nv_init), .nv_bits(nv_bits), .rd_data(8'ha5), .rd_addr(rd_addr),
        .wr_start(wr_start), .wr_kind(wr_kind), .wr_addr(wr_addr), .status_o(status_o)
    );
    sep_spi_master_model #(.HALF_NS(16)) i_sep_spi_master_model (
        .sck(sck), .cs_n(cs_n), .mosi(mosi), .sdo_o(sdo_o), .sdo_oe(sdo_oe)
    );

    // ------------------------------------------------------------
    // clock, timeout and write start counter
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (wr_start === 1'b1) n_starts <= n_starts + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            errors++;
        end
    endtask : check
    task automatic xfer(input logic [31:0] tx, input int nb);
        i_sep_spi_master_model.frame(tx, nb, rx, oe_seen);
        repeat (8) @(posedge clk);
    endtask : xfer
    function automatic logic [15:0] st(input logic [2:0] nv, input logic lat, input logic bsy);
        return {8'h00, nv[2], 3'b000, nv[1:0], lat, bsy};
    endfunction : st
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n         = 1'b0;
        protect_pin_n = 1'b1;
        nv_init       = 3'b010;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        check(status_o, st(3'b010, 1'b0, 1'b0));
        check(16'(nv_bits), 16'h0002);
        xfer({8'h05, 16'h0000}, 24);
        check(rx[15:0], 16'h0808);
        xfer({8'h01, 8'h00}, 16);
        check(status_o, st(3'b010, 1'b0, 1'b0));
        xfer(32'h03, 7);
        xfer(32'h0c, 9);
        check(16'(status_o[1]), 16'h0);
        xfer(32'h06, 8);
        check(16'(status_o[1]), 16'h1);
        xfer(32'h04, 8);
        check(16'(status_o[1]), 16'h0);
        xfer(32'h06, 8);
        xfer({8'h01, 8'h00, 1'b0}, 17);
        check(16'(status_o[0]), 16'h0);
        xfer(32'h04, 8);
        xfer({8'hff, 8'h06}, 16);
        check(16'(oe_seen), 16'h0);
        check(16'(status_o[1]), 16'h0);
        // each protect size against the top byte of three quarters
        for (int bp = 0; bp < 4; bp++) begin
            xfer(32'h06, 8);
            xfer({8'h01, 4'h0, 2'(bp), 2'b00}, 16);
            repeat (WCYC + 10) @(posedge clk);
            check(status_o, st({1'b0, 2'(bp)}, 1'b0, 1'b0));
            lim = (bp == 0) ? 'h400 : (bp == 1) ? 'h300 : (bp == 2) ? 'h200 : 0;
            for (int k = 1; k < 4; k++) begin
                acc = ((k * 'h100 + 'hff) < lim);
                s0  = n_starts;
                xfer(32'h06, 8);
                xfer({8'h02, 6'h3f, 2'(k), 8'hff, 8'h5a}, 32);
                check(16'(n_starts - s0), 16'(acc));
                check(16'(status_o[1:0]), {14'h0, 1'b1, acc});
                if (acc) begin
                    check(wr_addr, {6'h00, 2'(k), 8'hff});
                    xfer({8'h05, 8'h00}, 16);
                    check(16'(rx[7:0]), st({1'b0, 2'(bp)}, 1'b1, 1'b1));
                end
                repeat (WCYC + 10) @(posedge clk);
                check(16'(status_o[1:0]), {14'h0, ~acc, 1'b0});
                xfer(32'h04, 8);
            end
        end
        // lock bit with the protect pin
        xfer(32'h06, 8);
        xfer({8'h01, 8'h8c}, 16);
        repeat (WCYC + 10) @(posedge clk);
        check(status_o, st(3'b111, 1'b0, 1'b0));
        protect_pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        xfer(32'h06, 8);
        xfer({8'h01, 8'h00}, 16);
        check(16'(status_o[0]), 16'h0);
        repeat (WCYC + 10) @(posedge clk);
        check(16'(nv_bits), 16'h7);
        protect_pin_n <= 1'b1;
        repeat (4) @(posedge clk);
        xfer(32'h04, 8);
        xfer(32'h06, 8);
        xfer({8'h01, 8'h00}, 16);
        repeat (WCYC + 10) @(posedge clk);
        check(16'(nv_bits), 16'h0);
        // identification page and lock
        xfer(32'h06, 8);
        xfer({8'h82, 16'h0400, 8'ha5}, 32);
        check(16'(wr_kind), 16'h3);
        xfer({8'h03, 16'h0000, 8'h00}, 32);
        check(16'(oe_seen), 16'h0);
        repeat (WCYC + 10) @(posedge clk);
        xfer(32'h06, 8);
        xfer({8'h82, 16'h0005, 8'ha5}, 32);
        check(16'(wr_kind), 16'h2);
        check(wr_addr, 16'h0005);
        repeat (WCYC + 10) @(posedge clk);
        xfer({8'h03, 16'h0000, 8'h00}, 32);
        check({15'h0, oe_seen}, 16'h1);
        check(16'(rx[7:0]), 16'h00a5);
        check(16'(rd_addr), 16'h0001);
        xfer({8'h83, 16'h0400, 8'h00}, 32);
        check({15'h0, oe_seen}, 16'h1);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
